// [hdl/pot_pkg.sv]
package pot_pkg;
    // Geometry of the potentiometer pair
    localparam int TAP_BITS     = 6;
    localparam int POT_COUNT    = 2;
    localparam int SAVED_COUNT  = 4;
    // Target address: fixed upper three bits, strap pins below them
    localparam logic [3:0] ADDR_FIXED  = 4'h5;
    // Instruction byte: opcode in upper nibble, pot in bit 2, saved index in bits 1:0
    localparam logic [3:0] OP_READ_TAP    = 4'h9;
    localparam logic [3:0] OP_WRITE_TAP   = 4'hA;
    localparam logic [3:0] OP_READ_SAVED  = 4'hB;
    localparam logic [3:0] OP_WRITE_SAVED = 4'hC;
    localparam logic [3:0] OP_RECALL      = 4'hD;
    localparam logic [3:0] OP_STORE       = 4'hE;
    localparam int OP_POS      = 4;
    localparam int POT_POS     = 2;
    localparam int INDEX_POS   = 0;
    localparam logic [5:0] TAP_RESET   = 6'h00;
    localparam logic [5:0] SAVED_RESET = 6'h20;
    // Bus clock rises that pass while a start crosses into the bus engine
    localparam logic [3:0] START_SEEN_BITS = 4'h3;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_INSTR = 3'b011,
        ST_DATA = 3'b010,
        ST_SEND = 3'b110,
        ST_SKIP = 3'b111
    } link_state_e;

    // Decoded instruction
    typedef struct packed {
        logic [3:0] op;
        logic       pot;
        logic [1:0] index;
    } instr_s;
endpackage

// [hdl/dual_pot_wiper_control.sv]
// Summary of operation
// (R1) Each pot has own 6-bit tap register
// (R2) Four 6-bit saved settings per pot
// (R3) Power-up recalls first saved setting to tap
// (R4) Tap and saved writes only over bus
// (R5) Four straps form low address bits
// (R6) Respond only when address matches straps
// (R7) Data line driven open-drain only
// (R8) All transfers timed on bus clock
// (R9) One tap per pot, from tap register
// (R10) Read, write, recall, store instructions supported
// (R11) Tap writes immediate; saved values kept
`timescale 1ns/100ps
module dual_pot_wiper_control
    import pot_pkg::*;
(
    input  wire logic                        clock,
    input  wire logic                        rstn,
    input  wire logic                        scl,
    input  wire logic                        sda_in,
    output logic                             sda_out,
    output logic                             sda_oe_n,
    input  wire logic                        device_id_pin_0,
    input  wire logic                        device_id_pin_1,
    input  wire logic                        device_id_pin_2,
    input  wire logic                        device_id_pin_3,
    output logic [POT_COUNT*TAP_BITS-1:0]    wiper_tap_select,
    output logic [POT_COUNT*(1<<TAP_BITS)-1:0] tap_onehot
);
    // Straps enter the bus-clock domain through two stages; the data line is launched by the
    // master on this clock's falling edge, so it belongs to this domain and is sampled directly
    logic [1:0] strap_sync [4];
    logic       sda_s;
    logic [3:0] straps;
    always_ff @(posedge scl or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < 4; i++) strap_sync[i] <= 2'h0;
        end
        else
        begin
            strap_sync[0] <= {strap_sync[0][0], device_id_pin_0};
            strap_sync[1] <= {strap_sync[1][0], device_id_pin_1};
            strap_sync[2] <= {strap_sync[2][0], device_id_pin_2};
            strap_sync[3] <= {strap_sync[3][0], device_id_pin_3};
        end
    end
    assign sda_s  = sda_in; // R8
    assign straps = {strap_sync[3][1], strap_sync[2][1], strap_sync[1][1], strap_sync[0][1]}; // R5

    // Start and stop watch the data line while the clock is high, on the system clock.
    // Clock and data pass two stages here too; no logic reads the first stage.
    logic [1:0] scl_m, sda_m;
    logic       scl_d, sda_d;
    logic       start_tgl, stop_tgl;
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            scl_m <= 2'h0;
            sda_m <= 2'h3;
            scl_d <= 1'b0;
            sda_d <= 1'b1;
            start_tgl <= 1'b0;
            stop_tgl <= 1'b0;
        end
        else
        begin
            scl_m <= {scl_m[0], scl};
            sda_m <= {sda_m[0], sda_in};
            scl_d <= scl_m[1];
            sda_d <= sda_m[1];
            if (scl_m[1] && scl_d && sda_d && !sda_m[1])
                start_tgl <= ~start_tgl;
            if (scl_m[1] && scl_d && !sda_d && sda_m[1])
                stop_tgl <= ~stop_tgl;
        end
    end

    // Condition toggles cross into the bus clock domain (R8)
    logic [2:0] start_x, stop_x;
    logic       start_ev, stop_ev;
    always_ff @(posedge scl or negedge rstn)
    begin
        if (!rstn)
        begin
            start_x <= 3'h0;
            stop_x <= 3'h0;
        end
        else
        begin
            start_x <= {start_x[1:0], start_tgl};
            stop_x <= {stop_x[1:0], stop_tgl};
        end
    end
    assign start_ev = start_x[2] ^ start_x[1];
    assign stop_ev  = stop_x[2] ^ stop_x[1];

    // Register bank; saved settings are not cleared by bus activity
    logic [TAP_BITS-1:0] tap   [POT_COUNT];
    logic [TAP_BITS-1:0] saved [POT_COUNT][SAVED_COUNT];
    logic                loaded;

    function automatic logic addr_hit(input logic [6:0] a, input logic [3:0] s);
        return a == {ADDR_FIXED[2:0], s};
    endfunction

    // Serial engine state
    link_state_e state, next_state;
    logic [3:0]  bit_cnt, next_bit_cnt;
    logic [7:0]  shreg, next_shreg;
    instr_s      instr, next_instr;
    logic        ack_phase, next_ack_phase;
    logic        drive_low, next_drive_low;
    logic        wr_tap, wr_saved, do_recall, do_store;
    logic [TAP_BITS-1:0] wdata;

    always_comb
    begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        // Shift on every rise: bits keep arriving while the start event crosses over
        next_shreg = {shreg[6:0], sda_s};
        next_instr = instr;
        next_ack_phase = ack_phase;
        next_drive_low = 1'b0;
        wr_tap = 1'b0;
        wr_saved = 1'b0;
        do_recall = 1'b0;
        do_store = 1'b0;
        wdata = shreg[TAP_BITS-1:0];
        if (start_ev)
        begin
            // Start is seen on the third rise; the master must hold the start long enough
            // for the system clock to catch it before the first rise, or the byte slips
            next_state = ST_ADDR;
            next_bit_cnt = START_SEEN_BITS;
            next_ack_phase = 1'b0;
        end
        else if (stop_ev)
            next_state = ST_IDLE;
        else if (state != ST_IDLE && state != ST_SKIP)
        begin
            if (ack_phase)
            begin
                next_ack_phase = 1'b0;
                next_bit_cnt = 4'h0;
                // Answer slot after a byte sent out: a released line means no more data
                if (state == ST_SEND && sda_s)
                    next_state = ST_SKIP;
                else if (state == ST_SEND)
                    next_shreg = {2'h0, (instr.op == OP_READ_TAP) ? tap[instr.pot] : saved[instr.pot][instr.index]};
            end
            else if (bit_cnt == 4'h7)
            begin
                next_ack_phase = 1'b1;
                next_shreg = {shreg[6:0], sda_s};
                case (state)
                    ST_ADDR:
                    begin
                        if (addr_hit(next_shreg[7:1], straps) && !next_shreg[0]) // R6
                        begin
                            next_state = ST_INSTR;
                            next_drive_low = 1'b1;
                        end
                        else
                            next_state = ST_SKIP;
                    end
                    ST_INSTR:
                    begin
                        next_instr = instr_s'({next_shreg[7:4], next_shreg[POT_POS], next_shreg[1:0]});
                        next_drive_low = 1'b1;
                        case (next_shreg[7:4]) // R10
                            OP_WRITE_TAP, OP_WRITE_SAVED: next_state = ST_DATA;
                            OP_READ_TAP, OP_READ_SAVED: next_state = ST_SEND;
                            OP_RECALL:
                            begin
                                do_recall = 1'b1;
                                next_state = ST_SKIP;
                            end
                            OP_STORE:
                            begin
                                do_store = 1'b1;
                                next_state = ST_SKIP;
                            end
                            default:
                            begin
                                next_drive_low = 1'b0;
                                next_state = ST_SKIP;
                            end
                        endcase
                    end
                    ST_DATA:
                    begin
                        next_drive_low = 1'b1;
                        wdata = next_shreg[TAP_BITS-1:0];
                        wr_tap = (instr.op == OP_WRITE_TAP); // R4
                        wr_saved = (instr.op == OP_WRITE_SAVED); // R4
                    end
                    ST_SEND:
                    begin
                        next_state = ST_SEND; // Master answers in the following slot
                    end
                    default: next_state = ST_SKIP;
                endcase
            end
            else
            begin
                next_bit_cnt = bit_cnt + 4'h1;
                next_shreg = {shreg[6:0], sda_s};
            end
        end
    end

    // Bus engine registers on the bus clock (R8)
    always_ff @(posedge scl or negedge rstn)
    begin
        if (!rstn)
        begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            instr <= '0;
            ack_phase <= 1'b0;
            drive_low <= 1'b0;
        end
        else
        begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            shreg <= next_shreg;
            instr <= next_instr;
            ack_phase <= next_ack_phase;
            drive_low <= next_drive_low;
        end
    end

    // Register bank updates; first saved setting recalled after reset
    always_ff @(posedge scl or negedge rstn)
    begin
        if (!rstn)
        begin
            loaded <= 1'b0;
            for (int p = 0; p < POT_COUNT; p++)
            begin
                tap[p] <= TAP_RESET;
                for (int k = 0; k < SAVED_COUNT; k++) saved[p][k] <= SAVED_RESET; // R2
            end
        end
        else
        begin
            loaded <= 1'b1;
            for (int p = 0; p < POT_COUNT; p++)
            begin
                if (!loaded)
                    tap[p] <= saved[p][0]; // R3
                else if (wr_tap && instr.pot == p[0])
                    tap[p] <= wdata; // R11
                else if (do_recall && next_instr.pot == p[0])
                    tap[p] <= saved[p][next_instr.index]; // R10
                for (int k = 0; k < SAVED_COUNT; k++)
                begin
                    if (wr_saved && instr.pot == p[0] && instr.index == k[1:0])
                        saved[p][k] <= wdata; // R11
                    else if (do_store && next_instr.pot == p[0] && next_instr.index == k[1:0])
                        saved[p][k] <= tap[p];
                end
            end
        end
    end

    // Data line changes after the falling clock edge so it is stable while high
    logic send_bit;
    always_ff @(negedge scl or negedge rstn)
    begin
        if (!rstn)
            send_bit <= 1'b1;
        else if (drive_low)
            send_bit <= 1'b0;
        else if (state == ST_SEND && !ack_phase)
            send_bit <= shreg[7]; // Register shifts left each rise, so the next bit sits on top
        else
            send_bit <= 1'b1;
    end
    assign sda_out  = 1'b0;      // R7
    assign sda_oe_n = send_bit;  // R7

    // Tap outputs and one-hot switch selection
    generate
        for (genvar g = 0; g < POT_COUNT; g++)
        begin : g_pot
            assign wiper_tap_select[g*TAP_BITS +: TAP_BITS] = tap[g]; // R1
            for (genvar t = 0; t < (1<<TAP_BITS); t++)
            begin : g_tap
                assign tap_onehot[g*(1<<TAP_BITS) + t] = (tap[g] == TAP_BITS'(t)); // R9
            end
        end
    endgenerate

    a_one_tap_only: assert property (@(posedge scl) disable iff (!rstn) // R9
        $onehot(tap_onehot[63:0]) && $onehot(tap_onehot[127:64])) else $error("tap select not one-hot");
    a_recall_first: assert property (@(posedge scl) disable iff (!rstn) // R3
        !loaded |=> tap[0] == $past(saved[0][0])) else $error("power-up recall failed");
    a_tap_write: assert property (@(posedge scl) disable iff (!rstn) // R11
        loaded && wr_tap |=> tap[$past(instr.pot)] == $past(wdata)) else $error("tap write lost");
    a_addr_miss: assert property (@(posedge scl) disable iff (!rstn) // R6
        state == ST_ADDR && !ack_phase && bit_cnt == 4'h7 && !addr_hit(shreg[6:0], straps)
        |=> state inside {ST_SKIP, ST_ADDR, ST_IDLE}) else $error("wrong address accepted");
    a_open_drain: assert property (@(posedge scl) disable iff (!rstn) // R7
        sda_out == 1'b0) else $error("data line driven high");
    a_saved_hold: assert property (@(posedge scl) disable iff (!rstn) // R2
        !wr_saved && !do_store |=> saved[1][3] == $past(saved[1][3])) else $error("saved setting changed");
    a_no_write_idle: assert property (@(posedge scl) disable iff (!rstn) // R4
        state == ST_IDLE |-> !wr_tap && !wr_saved) else $error("write outside bus transfer");
    a_ack_addr: assert property (@(posedge scl) disable iff (!rstn) // R5
        state == ST_ADDR && next_state == ST_INSTR |=> ##0 drive_low) else $error("address not acknowledged");
endmodule

// [verification/bus_master_model.sv]
`timescale 1ns/100ps
// Behavioural bus master; it owns the bus clock and pulls the data wire open-drain
module bus_master_model (
    output logic      scl,
    output logic      sda_m,
    input  wire logic sda
);
    localparam int Q = 20; // Quarter of the 80 ns bus clock

    // Bus idles high; the clock only runs inside frames or when asked
    initial
    begin
        scl = 1'b1;
        sda_m = 1'b1;
    end

    // Wake-up pulses with the data wire released
    task automatic idle_clocks(input int n);
        repeat (n)
        begin
            scl = 1'b0;
            #(2*Q);
            scl = 1'b1;
            #(2*Q);
        end
    endtask

    // Long hold times so the 40 MHz start/stop detector cannot miss them, and the start
    // toggle is set before the first clock rise of the frame
    task automatic start_cond();
        sda_m = 1'b1;
        scl = 1'b1;
        #(2*Q);
        sda_m = 1'b0;
        #(2*Q);
        scl = 1'b0;
        #(2*Q);
    endtask

    task automatic stop_cond();
        sda_m = 1'b0;
        #Q;
        scl = 1'b1;
        #(2*Q);
        sda_m = 1'b1;
        #(2*Q);
    endtask

    // Data changes only while the clock is low; sampled mid-high
    task automatic one_bit(input logic b, output logic s);
        sda_m = b;
        #Q;
        scl = 1'b1;
        #Q;
        s = sda;
        #Q;
        scl = 1'b0;
        #Q;
    endtask

    // Master is the only writer of registers; it releases the wire for ACK
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            one_bit(b[i], s);
        one_bit(1'b1, s);
        ack = ~s;
    endtask

    // Read one byte MSB first, then NACK to end the read
    task automatic get_byte(output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            one_bit(1'b1, s);
            b = {b[6:0], s};
        end
        one_bit(1'b1, s);
    endtask
endmodule

// [verification/dual_pot_wiper_control_bench.sv]
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin n_errors++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module dual_pot_wiper_control_bench;
    import pot_pkg::*;
    logic        clock, rstn, scl, sda_m, sda_out, sda_oe_n, sda, ack, m;
    logic [3:0]  straps, a, op;
    logic [3:0]  ops [7] = '{OP_READ_TAP, OP_WRITE_TAP, OP_READ_SAVED, OP_WRITE_SAVED, OP_RECALL, OP_STORE, 4'h3};
    logic [11:0] wiper, e;
    logic [127:0] onehot;
    logic [11:0] exp_q[$];
    logic [5:0]  rd_q[$];
    logic        ack_q[$];
    logic [7:0]  rd_val;
    logic [5:0]  tap [2];
    logic [5:0]  saved [2][4];
    logic [31:0] rng = 32'h00013622;
    int          n_errors = 0;
    int          checked = 0;
    event        tap_ev, rd_ev, ack_ev;

    // Wired-AND of master and device open-drain drivers with a pull-up
    assign sda = sda_m & (sda_oe_n | sda_out);

    dual_pot_wiper_control u_dual_pot_wiper_control (.clock(clock), .rstn(rstn), .scl(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .device_id_pin_0(straps[0]), .device_id_pin_1(straps[1]),
        .device_id_pin_2(straps[2]), .device_id_pin_3(straps[3]), .wiper_tap_select(wiper), .tap_onehot(onehot));
    bus_master_model u_bus_master_model (.scl(scl), .sda_m(sda_m), .sda(sda));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    // One switch closed per pot, at the tap register's value
    function automatic logic [127:0] hot(input logic [11:0] t);
        logic [127:0] h;
        h = '0;
        h[t[5:0]] = 1'b1;
        h[64 + t[11:6]] = 1'b1;
        return h;
    endfunction

    task automatic stop_test();
        if (n_errors == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // One frame; expectations are noted before the result can appear
    task automatic send(input logic [3:0] op, input logic p, input logic [1:0] i, input logic [7:0] d);
        m = (a === straps) && (op inside {[OP_READ_TAP:OP_STORE]});
        if (m)
        begin
            case (op)
                OP_WRITE_TAP:   tap[p] = d[5:0];
                OP_WRITE_SAVED: saved[p][i] = d[5:0];
                OP_RECALL:      tap[p] = saved[p][i];
                OP_STORE:       saved[p][i] = tap[p];
                OP_READ_TAP:    rd_q.push_back(tap[p]);
                OP_READ_SAVED:  rd_q.push_back(saved[p][i]);
                default: ;
            endcase
        end
        u_bus_master_model.start_cond();
        ack_q.push_back(a === straps);
        u_bus_master_model.put_byte({3'b101, a, 1'b0}, ack);
        ->ack_ev;
        ack_q.push_back(m);
        u_bus_master_model.put_byte({op, 1'b0, p, i}, ack);
        ->ack_ev;
        if (m && (op == OP_READ_TAP || op == OP_READ_SAVED))
        begin
            u_bus_master_model.get_byte(rd_val);
            ->rd_ev;
        end
        else if (op != OP_RECALL && op != OP_STORE)
        begin
            ack_q.push_back(m);
            u_bus_master_model.put_byte(d, ack);
            ->ack_ev;
        end
        u_bus_master_model.stop_cond();
        repeat (4) @(posedge clock);
        exp_q.push_back({tap[1], tap[0]});
        ->tap_ev;
    endtask

    initial
    begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    // Result watchers take the oldest note whenever a result is announced
    initial
        forever
        begin
            @(tap_ev);
            e = exp_q.pop_front();
            `CHK(wiper, e)
            `CHK(onehot, hot(e))
        end
    initial
        forever
        begin
            @(rd_ev);
            `CHK(rd_val, {2'h0, rd_q.pop_front()})
        end
    // Acknowledge seen by the master against the expected answer of each byte
    initial
        forever
        begin
            @(ack_ev);
            `CHK(ack, ack_q.pop_front())
        end

    // Guard against a hung bus engine
    initial
    begin
        #400000;
        n_errors++;
        stop_test();
    end

    initial
    begin
        rstn = 1'b0;
        straps = 4'h0;
        fork
            u_bus_master_model.idle_clocks(4);
            repeat (12) @(posedge clock);
        join
        exp_q.push_back(12'h000);
        ->tap_ev;
        @(posedge clock);
        rstn <= 1'b1;
        u_bus_master_model.idle_clocks(4);
        // Power-up copies saved slot 0 into each tap
        foreach (saved[p, i])
            saved[p][i] = SAVED_RESET;
        tap = '{SAVED_RESET, SAVED_RESET};
        exp_q.push_back({tap[1], tap[0]});
        ->tap_ev;
        // Every opcode plus an unknown one; the second round uses a foreign address
        for (int k = 0; k < 28; k++)
        begin
            rng = xs(rng);
            @(posedge clock);
            straps <= rng[3:0];
            @(posedge clock);
            a = (k / 7 == 1) ? ~straps : straps;
            send(ops[k % 7], rng[4], rng[6:5], rng[15:8]);
        end
        stop_test();
    end
endmodule
